// ---- design/mfc_config_space.sv ----
/*
 * configuration space of the modem function of a two-function lan/modem
 * controller: base address registers, identity words mirrored from eeprom,
 * power management block, shared interrupt pin and boot rom coexistence.
 * assumes the config port delivers one request per cycle at most, eeprom
 * values are stable after load, and the eeprom reader answers cis words
 * combinationally from o_cis_ee_addr.
 */
`timescale 1ns/1ns
module mfc_config_space (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire mfc_pkg::mfc_cfg_req_t i_cfg,
	input wire mfc_pkg::mfc_ee_t i_ee,
	input wire mfc_pkg::mfc_bus_t i_bus,
	input wire logic [31:0] i_cis_ee_word,
	input wire logic i_aux_power,
	input wire logic i_pci_mode,
	input wire logic i_modem_enable_bit,
	input wire logic i_boot_disable_bit,
	input wire logic i_lan_boot_enable,
	input wire logic i_modem_irq,
	input wire logic i_lan_irq,
	input wire logic i_pme_event,
	input wire logic i_parity_err,
	input wire logic i_sys_err,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_ack,
	output mfc_pkg::mfc_hit_t o_hit,
	output logic [11:0] o_cis_ee_addr,
	output logic [31:0] o_cis_rdata,
	output logic o_cis_valid,
	output logic o_inta_out,
	output logic o_inta_oe,
	output logic o_modem_active,
	output logic o_bootrom_active,
	output logic o_shared_sel_modem,
	output logic [1:0] o_power_state
);
	import mfc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// complete register state of the block
	typedef struct packed {
		logic [15:0] cmd;
		logic st_perr;
		logic st_serr;
		logic [31:0] io_bar;
		logic [31:0] mem_bar;
		logic [7:0] int_line;
		logic [1:0] pm_state;
		logic pme_en;
		logic [3:0] dsel;
		logic pme_status;
		logic [31:0] rdata;
		logic ack;
		mfc_hit_t hit;
		logic [11:0] cis_addr;
		logic [31:0] cis_rdata;
		logic cis_valid;
		logic inta_drive;
		logic modem_active;
		logic bootrom_active;
		logic sel_modem;
	} mfc_state_t;

	mfc_state_t s;
	mfc_state_t next_s;
	logic [7:0] pwr_data;
	logic [1:0] pwr_scale;
	logic cfg_wr;
	logic [31:0] old_word;
	logic [15:0] pmcsr_word;

	////////////////////////////////////////////////////////////////////////
	// helpers

	// byte-lane write of the bits that the mask allows
	function automatic logic [31:0] mfc_merge(input logic [31:0] old, input logic [31:0] wdata,
			input logic [3:0] be, input logic [31:0] wmask);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			for (int k = 0; k < 8; k++) begin
				if (be[b] && wmask[b*8+k]) begin
					res[b*8+k] = wdata[b*8+k];
				end
			end
		end
		return res;
	endfunction

	// true when a write with a one lands on the given bit
	function automatic logic mfc_w1(input logic wr, input logic [31:0] wdata, input logic [3:0] be,
			input int bitpos);
		return wr && be[bitpos/8] && wdata[bitpos];
	endfunction

	// address falls inside a naturally aligned window
	function automatic logic mfc_in_window(input logic [31:0] addr, input logic [31:0] base,
			input logic [31:0] mask);
		return (addr & mask) == (base & mask);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// power report value for the data byte
	mfc_power_report u_power_report (
		.i_data_select(s.dsel),
		.i_consumed(i_ee.power_consumed),
		.i_dissipated(i_ee.power_dissipated),
		.o_data(pwr_data),
		.o_scale(pwr_scale)
	);

	// control/status word as software sees it
	always_comb begin
		pmcsr_word = '0;
		pmcsr_word[MFC_PM_PS_LSB +: 2] = s.pm_state;
		pmcsr_word[MFC_PM_PME_EN] = s.pme_en;
		pmcsr_word[MFC_PM_DSEL_LSB +: 4] = s.dsel;
		pmcsr_word[MFC_PM_DSCALE_LSB +: 2] = pwr_scale;
		pmcsr_word[MFC_PM_PME_ST] = s.pme_status;
	end

	////////////////////////////////////////////////////////////////////////
	// read mux of the configuration space; unlisted offsets read zero
	always_comb begin
		old_word = '0;
		unique case (i_cfg.addr)
			MFC_OFF_ID: old_word = {i_ee.device_id, i_ee.vendor_id};
			MFC_OFF_CMD: begin
				old_word = {MFC_STATUS_CONST, s.cmd};
				old_word[16 + MFC_ST_PERR] = s.st_perr;
				old_word[16 + MFC_ST_SERR] = s.st_serr;
			end
			MFC_OFF_REV: old_word = {MFC_CLASS_CODE, i_ee.revision};
			MFC_OFF_HDR: old_word = {8'h00, MFC_HEADER_TYPE, 16'h0000};
			MFC_OFF_IOBAR: old_word = (s.io_bar & MFC_IO_BAR_MASK) | MFC_IO_BAR_FLAG;
			MFC_OFF_MEMBAR: old_word = s.mem_bar & MFC_MEM_BAR_MASK;
			// pointer only exists on cardbus; reserved in pci mode
			MFC_OFF_CIS: old_word = i_pci_mode ? 32'h0000_0000 : MFC_CIS_PTR;
			MFC_OFF_SUBSYS: old_word = {i_ee.subsys_id, i_ee.subsys_vendor};
			MFC_OFF_CAP: old_word = {24'h00_0000, MFC_CAP_PTR};
			MFC_OFF_INTR: old_word = {16'h0000, MFC_INT_PIN, s.int_line};
			MFC_OFF_PMCAP: begin
				old_word = {(i_aux_power ? MFC_PMC_AUX : MFC_PMC_NOAUX), MFC_PM_NEXT, MFC_PM_CAP_ID};
			end
			MFC_OFF_PMCSR: old_word = {8'h00, pwr_data, pmcsr_word};
			default: old_word = '0;
		endcase
	end

	assign cfg_wr = i_cfg.valid && i_cfg.write;

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		logic [31:0] merged;
		logic io_ok;
		logic mem_ok;
		logic [11:0] ofs;
		merged = '0;
		io_ok = 1'b0;
		mem_ok = 1'b0;
		ofs = '0;
		next_s = s;

		// config writes; read-only words ignore the write
		next_s.ack = i_cfg.valid;
		if (i_cfg.valid && !i_cfg.write) begin
			next_s.rdata = old_word;
		end
		if (cfg_wr) begin
			unique case (i_cfg.addr)
				MFC_OFF_CMD: begin
					merged = mfc_merge({16'h0000, s.cmd}, i_cfg.wdata, i_cfg.be, {16'h0000, MFC_CMD_WMASK});
					next_s.cmd = merged[15:0];
				end
				MFC_OFF_IOBAR: begin
					next_s.io_bar = mfc_merge(s.io_bar, i_cfg.wdata, i_cfg.be, MFC_IO_BAR_MASK);
				end
				MFC_OFF_MEMBAR: begin
					next_s.mem_bar = mfc_merge(s.mem_bar, i_cfg.wdata, i_cfg.be, MFC_MEM_BAR_MASK);
				end
				MFC_OFF_INTR: begin
					merged = mfc_merge({24'h00_0000, s.int_line}, i_cfg.wdata, i_cfg.be, 32'h0000_00FF);
					next_s.int_line = merged[7:0];
				end
				MFC_OFF_PMCSR: begin
					merged = mfc_merge({16'h0000, pmcsr_word}, i_cfg.wdata, i_cfg.be, {16'h0000, MFC_PM_WMASK});
					next_s.pm_state = merged[MFC_PM_PS_LSB +: 2];
					next_s.pme_en = merged[MFC_PM_PME_EN];
					next_s.dsel = merged[MFC_PM_DSEL_LSB +: 4];
				end
				default: next_s.cmd = s.cmd;
			endcase
		end

		// sticky status bits: write one clears, a new event in the same cycle wins
		if (cfg_wr && i_cfg.addr == MFC_OFF_CMD && mfc_w1(cfg_wr, i_cfg.wdata, i_cfg.be, 16 + MFC_ST_PERR)) begin
			next_s.st_perr = 1'b0;
		end
		if (cfg_wr && i_cfg.addr == MFC_OFF_CMD && mfc_w1(cfg_wr, i_cfg.wdata, i_cfg.be, 16 + MFC_ST_SERR)) begin
			next_s.st_serr = 1'b0;
		end
		if (i_parity_err) begin
			next_s.st_perr = 1'b1;
		end
		if (i_sys_err) begin
			next_s.st_serr = 1'b1;
		end
		if (cfg_wr && i_cfg.addr == MFC_OFF_PMCSR && mfc_w1(cfg_wr, i_cfg.wdata, i_cfg.be, MFC_PM_PME_ST)) begin
			next_s.pme_status = 1'b0;
		end
		if (i_pme_event) begin
			next_s.pme_status = 1'b1;
		end

		// target decode of the modem windows, gated by the command bits
		io_ok = i_bus.valid && !i_bus.mem && s.cmd[MFC_CMD_IO_EN] && s.modem_active;
		mem_ok = i_bus.valid && i_bus.mem && s.cmd[MFC_CMD_MEM_EN] && s.modem_active;
		ofs = i_bus.addr[11:0];
		next_s.hit.io_hit = io_ok && mfc_in_window(i_bus.addr, s.io_bar, MFC_IO_BAR_MASK);
		next_s.hit.mem_hit = mem_ok && mfc_in_window(i_bus.addr, s.mem_bar, MFC_MEM_BAR_MASK);
		next_s.hit.cis_hit = next_s.hit.mem_hit && (ofs >= MFC_CIS_BASE);
		next_s.hit.mem_offset = next_s.hit.mem_hit ? ofs : 12'h000;

		// card info reads: address out this cycle, eeprom word back the next
		next_s.cis_valid = s.hit.cis_hit && !s.cis_valid && !i_bus.write;
		if (next_s.hit.cis_hit && !i_bus.write) begin
			next_s.cis_addr = ofs - MFC_CIS_BASE;
		end
		if (s.hit.cis_hit && !s.cis_valid) begin
			next_s.cis_rdata = i_cis_ee_word;
		end

		// one open-drain interrupt pin for both functions
		next_s.inta_drive = (i_modem_irq && s.modem_active) || i_lan_irq;

		// modem and boot rom coexistence; the system keeps the shared port private
		next_s.modem_active = i_modem_enable_bit;
		next_s.bootrom_active = !i_boot_disable_bit;
		if (i_pci_mode && i_modem_enable_bit && !i_boot_disable_bit) begin
			next_s.sel_modem = !i_lan_boot_enable;
		end else begin
			next_s.sel_modem = i_modem_enable_bit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register; everything clears on the synchronous bus reset
	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from the state, except o_inta_out which is tied low
	assign o_cfg_rdata = s.rdata;
	assign o_cfg_ack = s.ack;
	assign o_hit = s.hit;
	assign o_cis_ee_addr = s.cis_addr;
	assign o_cis_rdata = s.cis_rdata;
	assign o_cis_valid = s.cis_valid;
	assign o_inta_out = 1'b0; // pin only ever pulls low
	assign o_inta_oe = s.inta_drive;
	assign o_modem_active = s.modem_active;
	assign o_bootrom_active = s.bootrom_active;
	assign o_shared_sel_modem = s.sel_modem;
	assign o_power_state = s.pm_state;

endmodule

// ---- design/mfc_pkg.sv ----
/*
 * constants and carrier types for the modem function configuration space.
 * assumes a single core clock domain and byte addresses on the config port.
 */
package mfc_pkg;

	////////////////////////////////////////////////////////////////////////
	// configuration space byte offsets
	localparam logic [7:0] MFC_OFF_ID = 8'h00;
	localparam logic [7:0] MFC_OFF_CMD = 8'h04;
	localparam logic [7:0] MFC_OFF_REV = 8'h08;
	localparam logic [7:0] MFC_OFF_HDR = 8'h0C;
	localparam logic [7:0] MFC_OFF_IOBAR = 8'h10;
	localparam logic [7:0] MFC_OFF_MEMBAR = 8'h14;
	localparam logic [7:0] MFC_OFF_CIS = 8'h28;
	localparam logic [7:0] MFC_OFF_SUBSYS = 8'h2C;
	localparam logic [7:0] MFC_OFF_EXPROM = 8'h30;
	localparam logic [7:0] MFC_OFF_CAP = 8'h34;
	localparam logic [7:0] MFC_OFF_INTR = 8'h3C;
	localparam logic [7:0] MFC_OFF_PMCAP = 8'hDC;
	localparam logic [7:0] MFC_OFF_PMCSR = 8'hE0;

	////////////////////////////////////////////////////////////////////////
	// window sizes and hardwired base address bits
	localparam logic [31:0] MFC_IO_BAR_MASK = 32'hFFFF_FFF8;
	localparam logic [31:0] MFC_IO_BAR_FLAG = 32'h0000_0001;
	localparam logic [31:0] MFC_MEM_BAR_MASK = 32'hFFFF_F000;
	localparam logic [11:0] MFC_CIS_BASE = 12'h100;
	localparam logic [31:0] MFC_CIS_PTR = 32'h0000_0102;

	////////////////////////////////////////////////////////////////////////
	// hard-coded register contents
	localparam logic [15:0] MFC_STATUS_CONST = 16'h0210;
	localparam logic [15:0] MFC_CMD_WMASK = 16'h0143;
	localparam logic [23:0] MFC_CLASS_CODE = 24'h07_0002;
	localparam logic [7:0] MFC_HEADER_TYPE = 8'h80;
	localparam logic [7:0] MFC_CAP_PTR = 8'hDC;
	localparam logic [7:0] MFC_INT_PIN = 8'h01;
	localparam logic [15:0] MFC_PMC_AUX = 16'hFE31;
	localparam logic [15:0] MFC_PMC_NOAUX = 16'h7E21;
	localparam logic [7:0] MFC_PM_CAP_ID = 8'h01;
	localparam logic [7:0] MFC_PM_NEXT = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int MFC_CMD_IO_EN = 0;
	localparam int MFC_CMD_MEM_EN = 1;
	localparam int MFC_ST_SERR = 14;
	localparam int MFC_ST_PERR = 15;
	localparam int MFC_PM_PS_LSB = 0;
	localparam int MFC_PM_PME_EN = 8;
	localparam int MFC_PM_DSEL_LSB = 9;
	localparam int MFC_PM_DSCALE_LSB = 13;
	localparam int MFC_PM_PME_ST = 15;
	localparam logic [15:0] MFC_PM_WMASK = 16'h1F03;
	localparam logic [1:0] MFC_SCALE_PWR = 2'h2;
	localparam logic [1:0] MFC_SCALE_NONE = 2'h0;
	localparam logic [7:0] MFC_DATA_NONE = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// carriers
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} mfc_cfg_req_t;

	typedef struct packed {
		logic [15:0] device_id;
		logic [15:0] vendor_id;
		logic [7:0] revision;
		logic [15:0] subsys_vendor;
		logic [15:0] subsys_id;
		logic [3:0][7:0] power_consumed;
		logic [3:0][7:0] power_dissipated;
	} mfc_ee_t;

	typedef struct packed {
		logic valid;
		logic mem;
		logic write;
		logic [31:0] addr;
	} mfc_bus_t;

	typedef struct packed {
		logic io_hit;
		logic mem_hit;
		logic cis_hit;
		logic [11:0] mem_offset;
	} mfc_hit_t;

endpackage

// ---- design/mfc_power_report.sv ----
/*
 * power report selector for the data register next to the power control word.
 * assumes the consumed and dissipated figures are static eeprom values.
 */
`timescale 1ns/1ns
module mfc_power_report (
	input wire logic [3:0] i_data_select,
	input wire logic [3:0][7:0] i_consumed,
	input wire logic [3:0][7:0] i_dissipated,
	output logic [7:0] o_data,
	output logic [1:0] o_scale
);
	import mfc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// select 0..3 consumption, 4..7 dissipation, 8..15 nothing
	always_comb begin
		o_data = MFC_DATA_NONE;
		o_scale = MFC_SCALE_NONE;
		if (!i_data_select[3]) begin
			o_scale = MFC_SCALE_PWR;
			if (i_data_select[2]) begin
				o_data = i_dissipated[i_data_select[1:0]];
			end else begin
				o_data = i_consumed[i_data_select[1:0]];
			end
		end
	end

endmodule

// ---- tb/mfc_config_space_checker.sv ----
/*
 * concurrent checks on the modem config space ports.
 * assumes one clock, synchronous active high reset, bound to the top module.
 */
`timescale 1ns/1ns
module mfc_config_space_checker (
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	input wire mfc_pkg::mfc_cfg_req_t i_cfg,
	input wire mfc_pkg::mfc_ee_t i_ee,
	input wire mfc_pkg::mfc_bus_t i_bus,
	input wire logic [31:0] i_cis_ee_word,
	input wire logic i_aux_power,
	input wire logic i_pci_mode,
	input wire logic i_modem_enable_bit,
	input wire logic i_boot_disable_bit,
	input wire logic i_lan_boot_enable,
	input wire logic i_lan_irq,
	input wire logic [31:0] o_cfg_rdata,
	input wire logic o_cfg_ack,
	input wire mfc_pkg::mfc_hit_t o_hit,
	input wire logic [31:0] o_cis_rdata,
	input wire logic o_cis_valid,
	input wire logic o_inta_oe,
	input wire logic o_bootrom_active,
	input wire logic o_shared_sel_modem
);
	import mfc_pkg::*;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	////////////////////////////////////////////////////////////////////////
	// expected scale and data byte of the power report
	function automatic logic [9:0] pdat(logic [3:0] s, mfc_ee_t e);
		return s < 4 ? {MFC_SCALE_PWR, e.power_consumed[s[1:0]]} :
			s < 8 ? {MFC_SCALE_PWR, e.power_dissipated[s[1:0]]} : 10'h000;
	endfunction
	sequence s_rd(logic [7:0] a);
		i_cfg.valid && !i_cfg.write && i_cfg.addr == a;
	endsequence
	// a second hit right behind the first gets no fresh word, so skip it
	sequence s_cis;
		i_bus.valid && i_bus.mem ##1 o_hit.cis_hit && !o_cis_valid;
	endsequence
	////////////////////////////////////////////////////////////////////////
	AST_CFG_ACK: assert property (i_cfg.valid |=> o_cfg_ack) else $error("no ack after request");
	AST_CFG_NOACK: assert property (!i_cfg.valid |=> !o_cfg_ack) else $error("ack without request");
	AST_IOBAR_LOW: assert property (s_rd(MFC_OFF_IOBAR) |=> o_cfg_rdata[2:0] == 3'b001)
		else $error("io base low bits wrong");
	AST_MEMBAR_LOW: assert property (s_rd(MFC_OFF_MEMBAR) |=> o_cfg_rdata[11:0] == 12'h000)
		else $error("memory base low bits wrong");
	AST_CIS_PTR: assert property (s_rd(MFC_OFF_CIS) and !i_pci_mode |=> o_cfg_rdata == MFC_CIS_PTR)
		else $error("card info pointer wrong");
	AST_CIS_WORD: assert property (s_cis |=> o_cis_valid && o_cis_rdata == $past(i_cis_ee_word))
		else $error("card info word not from eeprom");
	AST_SUBSYS: assert property (s_rd(MFC_OFF_SUBSYS) |=> o_cfg_rdata == {i_ee.subsys_id, i_ee.subsys_vendor})
		else $error("subsystem words wrong");
	AST_CAP_PTR: assert property (s_rd(MFC_OFF_CAP) |=> o_cfg_rdata[7:0] == MFC_CAP_PTR)
		else $error("capability pointer wrong");
	AST_PM_CAP: assert property (s_rd(MFC_OFF_PMCAP) |=> o_cfg_rdata ==
		{$past(i_aux_power) ? MFC_PMC_AUX : MFC_PMC_NOAUX, MFC_PM_NEXT, MFC_PM_CAP_ID}) else $error("pm caps wrong");
	AST_PM_DATA: assert property (s_rd(MFC_OFF_PMCSR) |=>
		{o_cfg_rdata[14:13], o_cfg_rdata[23:16]} == pdat(o_cfg_rdata[12:9], i_ee)) else $error("power data wrong");
	AST_INTA: assert property (i_lan_irq |=> o_inta_oe) else $error("shared interrupt not driven");
	AST_COEXIST: assert property (i_pci_mode && i_modem_enable_bit && !i_boot_disable_bit |=>
		o_bootrom_active && o_shared_sel_modem == !$past(i_lan_boot_enable)) else $error("coexistence wrong");
endmodule
bind mfc_config_space mfc_config_space_checker mfc_config_space_checker_inst (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_cfg(i_cfg), .i_ee(i_ee), .i_bus(i_bus), .i_cis_ee_word(i_cis_ee_word),
	.i_aux_power(i_aux_power), .i_pci_mode(i_pci_mode), .i_modem_enable_bit(i_modem_enable_bit),
	.i_boot_disable_bit(i_boot_disable_bit), .i_lan_boot_enable(i_lan_boot_enable), .i_lan_irq(i_lan_irq),
	.o_cfg_rdata(o_cfg_rdata), .o_cfg_ack(o_cfg_ack), .o_hit(o_hit), .o_cis_rdata(o_cis_rdata),
	.o_cis_valid(o_cis_valid), .o_inta_oe(o_inta_oe), .o_bootrom_active(o_bootrom_active),
	.o_shared_sel_modem(o_shared_sel_modem));

// ---- tb/mfc_eeprom_model.sv ----
/*
 * eeprom side of the modem config space: loaded words and card info reads.
 * assumes the design reads the card info word combinationally from its address.
 */
`timescale 1ns/1ns
module mfc_eeprom_model (
	input wire logic [11:0] i_cis_ee_addr,
	output mfc_pkg::mfc_ee_t o_ee,
	output logic [31:0] o_cis_ee_word
);
	import mfc_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// loaded words; identity values are arbitrary, power bytes distinct per state
	assign o_ee = '{16'h0B0E, 16'h0A0D, 8'h01, 16'h3C0F, 16'h5A11,
		{8'h13, 8'h12, 8'h11, 8'h10}, {8'h23, 8'h22, 8'h21, 8'h20}};
	// address folded into the word so a wrong offset cannot pass unseen
	// nothing else hangs on the shared flash/modem lines
	assign o_cis_ee_word = {8'hA5, 12'h5A5, i_cis_ee_addr};
endmodule

// ---- tb/tb_mfc_config_space.sv ----
/*
 * self-checking bench for the modem config space: config reads and writes, decode.
 * assumes the eeprom model feeds loaded words; inputs change on the falling edge.
 */
`timescale 1ns/1ns
module tb_mfc_config_space;
	import mfc_pkg::*;
	logic clk = 0, rst = 1, aux = 1, pci = 0, modem_enable_bit = 1, bd = 0, lboot = 0, mirq = 0, lirq = 0, pme = 0;
	logic ack, cv, oe, io, ma, ba, ssm;
	logic [31:0] rd, crd, eew;
	logic [11:0] eea;
	logic [1:0] ps;
	mfc_cfg_req_t cfg_r = '0;
	mfc_bus_t bus = '0;
	mfc_ee_t ee;
	mfc_hit_t hit;
	int fails = 0, checks = 0;
	always #4 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	mfc_eeprom_model mfc_eeprom_model_inst (.i_cis_ee_addr(eea), .o_ee(ee), .o_cis_ee_word(eew));
	mfc_config_space mfc_config_space_inst (.i_core_clk(clk), .i_sys_rst(rst), .i_cfg(cfg_r), .i_ee(ee),
		.i_bus(bus), .i_cis_ee_word(eew), .i_aux_power(aux), .i_pci_mode(pci), .i_modem_enable_bit(modem_enable_bit),
		.i_boot_disable_bit(bd), .i_lan_boot_enable(lboot), .i_modem_irq(mirq), .i_lan_irq(lirq),
		.i_pme_event(pme), .i_parity_err(1'b0), .i_sys_err(1'b0), .o_cfg_rdata(rd), .o_cfg_ack(ack),
		.o_hit(hit), .o_cis_ee_addr(eea), .o_cis_rdata(crd), .o_cis_valid(cv), .o_inta_out(io),
		.o_inta_oe(oe), .o_modem_active(ma), .o_bootrom_active(ba), .o_shared_sel_modem(ssm),
		.o_power_state(ps));
	////////////////////////////////////////////////////////////////////////
	task check(string n, logic [47:0] s, logic [47:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	// one request pulse; the answer is fixed at the next edge
	task cfg(logic w, logic [7:0] a, logic [3:0] b, logic [31:0] d);
		@(negedge clk);
		cfg_r = '{1'b1, w, a, b, d};
		@(negedge clk);
		cfg_r.valid = 0;
		check("ack", ack, 1);
	endtask
	task rdchk(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
		cfg(0, a, 0, 0);
		check(n, rd & m, e);
	endtask
	task acc(logic m, logic [31:0] a);
		@(negedge clk);
		bus = '{1'b1, m, 1'b0, a};
		@(negedge clk);
		bus.valid = 0;
	endtask
	task report_and_stop;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// hang guard, far beyond the sequence length
	initial begin
		#200000;
		fails++;
		report_and_stop;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(negedge clk);
		rst = 0;
		rdchk("cmd", MFC_OFF_CMD, 32'h0000_FFFF, 0);
		cfg(1, MFC_OFF_IOBAR, 4'hF, 32'hFFFF_FFFF);
		rdchk("iobar", MFC_OFF_IOBAR, '1, 32'hFFFF_FFF9);
		cfg(1, MFC_OFF_MEMBAR, 4'hF, 32'hFFFF_FFFF);
		rdchk("membar", MFC_OFF_MEMBAR, '1, 32'hFFFF_F000);
		rdchk("cisptr", MFC_OFF_CIS, '1, 32'h0000_0102);
		cfg(1, MFC_OFF_SUBSYS, 4'hF, 0);
		rdchk("subsys", MFC_OFF_SUBSYS, '1, {ee.subsys_id, ee.subsys_vendor});
		cfg(1, MFC_OFF_CAP, 4'hF, 0);
		rdchk("capptr", MFC_OFF_CAP, 32'h0000_00FF, 32'h0000_00DC);
		rdchk("intpin", MFC_OFF_INTR, 32'h0000_FF00, 32'h0000_0100);
		for (int i = 0; i < 2; i++) begin
			aux = i[0];
			rdchk("pmcap", MFC_OFF_PMCAP, '1, {i ? 16'hFE31 : 16'h7E21, 16'h0001});
		end
		// every data select code, read back with its scale
		for (int s = 0; s < 16; s++) begin
			cfg(1, MFC_OFF_PMCSR, 4'h3, 32'(s) << 9);
			cfg(0, MFC_OFF_PMCSR, 0, 0);
			check("pscale", rd[14:13], s < 8 ? 2 : 0);
			check("pdata", rd[23:16], s < 4 ? ee.power_consumed[s] : s < 8 ? ee.power_dissipated[s-4] : 0);
		end
		cfg(1, MFC_OFF_PMCSR, 4'h3, 32'h0000_0103);
		rdchk("pmcsr", MFC_OFF_PMCSR, 32'h0000_1F03, 32'h0000_0103);
		check("pstate", ps, 3);
		@(negedge clk);
		pme = 1;
		@(negedge clk);
		pme = 0;
		rdchk("pmest", MFC_OFF_PMCSR, 32'h0000_8000, 32'h0000_8000);
		cfg(1, MFC_OFF_PMCSR, 4'h3, 32'h0000_8000);
		rdchk("pmeclr", MFC_OFF_PMCSR, 32'h0000_8003, 0);
		// both functions pull the one shared line
		for (int k = 0; k < 3; k++) begin
			{lirq, mirq} = k[1:0];
			repeat (2) @(negedge clk);
			check("inta", oe, k != 0);
			check("intaout", io, 0);
		end
		pci = 1;
		for (int b = 0; b < 2; b++) begin
			lboot = b[0];
			repeat (2) @(negedge clk);
			check("coexist", {ma, ba, ssm}, {2'b11, ~lboot});
		end
		// the card info pointer only exists on cardbus; pci mode reads it as reserved
		rdchk("cisreserved", MFC_OFF_CIS, '1, 32'h0000_0000);
		pci = 0;
		// decode stays off until the command bits open it
		cfg(1, MFC_OFF_IOBAR, 4'hF, 32'h0000_1000);
		cfg(1, MFC_OFF_MEMBAR, 4'hF, 32'h8000_0000);
		acc(1, 32'h8000_0104);
		check("nohit", {hit.io_hit, hit.mem_hit, hit.cis_hit}, 0);
		cfg(1, MFC_OFF_CMD, 4'h3, 32'h0000_0003);
		acc(0, 32'h0000_1004);
		check("iohit", hit.io_hit, 1);
		acc(1, 32'h8000_0104);
		check("cishit", {hit.mem_hit, hit.cis_hit, eea}, {2'b11, 12'h004});
		check("memofs", hit.mem_offset, 12'h104);
		@(negedge clk);
		check("cisword", {cv, crd}, {1'b1, 8'hA5, 12'h5A5, 12'h004});
		report_and_stop;
	end
endmodule
